// ===== src/radio_link_spi.sv
// Three-wire serial master and radio register slave with flags
`timescale 1ns/1ps
`default_nettype none

module radio_link_spi
(
    input  wire logic sys_clk_i,            // System clock, 100 MHz
    input  wire logic reset_i,              // Async reset, active high
    input  wire logic ctrl_wr_i,            // Load enable bits
    input  wire logic master_enable_i,      // Master enable value
    input  wire logic block_enable_i,       // Block enable value
    input  wire logic clock_phase_bit_i,    // Clock phase
    input  wire logic clock_polarity_bit_i, // Idle clock level
    input  wire logic [radio_link_pkg::DIV_W-1:0]
                      clock_divider_register_i, // Half period - 1
    input  wire logic multi_master_i,       // Multi-master select mode
    input  wire logic fault_select_n_i,     // Fault sense pin, low
    input  wire logic slave_select_n_i,     // Radio select pin, low
    input  wire logic int_enable_i,         // Interrupt enable
    input  wire logic data_wr_i,            // Data port write strobe
    input  wire logic [radio_link_pkg::BYTE_W-1:0]
                      data_wr_byte_i,       // Data port write value
    input  wire logic clr_done_i,           // Clear transfer done
    input  wire logic clr_collision_i,      // Clear write collision
    input  wire logic clr_fault_i,          // Clear mode fault
    output logic [radio_link_pkg::BYTE_W-1:0]
                      rx_byte_o,            // Data port read value
    output logic      master_enable_bit_o,  // Master enable state
    output logic      block_enable_bit_o,   // Block enable state
    output logic      transfer_done_flag_o, // Byte finished
    output logic      write_collision_flag_o, // Write refused
    output logic      mode_fault_flag_o,    // Mode fault seen
    output logic      tx_buffer_empty_flag_o, // Buffer may be written
    output logic      busy_o,               // Transfer running
    output logic      irq_o,                // Interrupt request
    output logic      sck_o,                // Serial clock
    output logic      mosi_o,               // Master data out
    output logic      miso_o,               // Slave data out
    output logic      miso_oe_o             // Slave driver enable
);
    import radio_link_pkg::*;

    typedef struct packed {
        mst_e              st;
        logic [BYTE_W-1:0] txbuf;
        logic              txbmt;
        logic [BYTE_W-1:0] sh;
        logic [BYTE_W-1:0] rxbuf;
        logic [2:0]        bitn;
        logic              second;
        logic [CNT_W-1:0]  cnt;
        logic              sck;
        logic              done;
        logic              wcol;
        logic              modf;
        logic              irq;
        logic              master_enable_bit;
        logic              en;
        logic              busy;
    } mst_s;

    localparam mst_s MST_RST = '{st: M_IDLE, txbmt: 1'b1, default: '0};

    mst_s             q;
    mst_s             n;
    logic [CNT_W-1:0] div_len;
    logic [CNT_W-1:0] half_len;
    logic             byte_end;
    logic             slv_miso;
    logic             slv_oe;
    logic             lead;
    logic             fault;
    logic             wr_ok;
    logic [2:0]       lead_cnt_ff;

    // Half period never drops below the 12.5 MHz ceiling
    always_comb
    begin
        div_len  = {1'b0, clock_divider_register_i} + CNT_ONE;
        half_len = (div_len < HALF_MIN_CNT) ? HALF_MIN_CNT : div_len;
    end

    assign fault = multi_master_i && q.master_enable_bit && !fault_select_n_i;
    assign wr_ok = data_wr_i && q.en && q.master_enable_bit;

    // Master sequencer, flags and buffers
    always_comb
    begin
        n        = q;
        byte_end = 1'b0;
        if (ctrl_wr_i)
        begin
            n.master_enable_bit = master_enable_i;
            n.en    = block_enable_i;
        end
        // Fault wins over a same-cycle control write
        if (fault)
        begin
            n.modf  = 1'b1;
            n.master_enable_bit = 1'b0;
            n.en    = 1'b0;
        end
        // Done and collision clears come first so a same-cycle set wins; the fault clear is blocked while fault is high
        if (clr_done_i)
            n.done = 1'b0;
        if (clr_collision_i)
            n.wcol = 1'b0;
        if (clr_fault_i && !fault)
            n.modf = 1'b0;
        if (wr_ok)
        begin
            if (q.txbmt)
            begin
                n.txbuf = data_wr_byte_i;
                n.txbmt = 1'b0;
            end
            else
            begin
                n.wcol = 1'b1;
            end
        end
        unique case (q.st)
            M_IDLE:
            begin
                if (q.en && q.master_enable_bit && !q.txbmt)
                begin
                    n.st     = M_SHIFT;
                    n.sh     = q.txbuf;
                    n.txbmt  = 1'b1;
                    n.bitn   = '0;
                    n.second = 1'b0;
                    n.cnt    = '0;
                end
            end
            M_SHIFT:
            begin
                if (!n.en || !n.master_enable_bit)
                begin
                    // Disable or fault abandons the byte
                    n.st = M_IDLE;
                end
                else if (q.cnt != half_len - CNT_ONE)
                begin
                    n.cnt = q.cnt + CNT_ONE;
                end
                else
                begin
                    n.cnt = '0;
                    if (!q.second)
                    begin
                        n.second = 1'b1;
                    end
                    else
                    begin
                        // Last cycle of the bit: sample late for settling
                        n.second = 1'b0;
                        n.sh = {q.sh[BYTE_W-2:0], slv_miso};
                        if (q.bitn != LAST_BIT)
                        begin
                            n.bitn = q.bitn + 1'b1;
                        end
                        else
                        begin
                            byte_end = 1'b1;
                            n.done   = 1'b1;
                            n.rxbuf  = {q.sh[BYTE_W-2:0], slv_miso};
                            n.bitn   = '0;
                            if (!q.txbmt)
                            begin
                                // Queued byte follows with no idle gap
                                n.sh    = q.txbuf;
                                n.txbmt = 1'b1;
                            end
                            else
                            begin
                                n.st = M_IDLE;
                            end
                        end
                    end
                end
            end
        endcase
        n.busy = (n.st == M_SHIFT);
        // Phase picks which half of the bit holds the active level
        n.sck = n.busy ?
                (clock_polarity_bit_i ^ clock_phase_bit_i ^ n.second) :
                clock_polarity_bit_i;
        n.irq = int_enable_i && (n.done || n.wcol || n.modf);
    end

    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
            q <= MST_RST;
        else
            q <= n;
    end

    // The radio's slave select is driven by the port pin, not by the master
    radio_reg_slave u_radio
    (
        .sys_clk_i        (sys_clk_i),
        .reset_i          (reset_i),
        .enable_i         (q.en),
        .slave_select_n_i (slave_select_n_i),
        .sck_i            (q.sck),
        .mosi_i           (q.sh[MSB]),
        .miso_o           (slv_miso),
        .miso_oe_o        (slv_oe)
    );

    // All outputs come from state flops
    assign rx_byte_o              = q.rxbuf;
    assign master_enable_bit_o    = q.master_enable_bit;
    assign block_enable_bit_o     = q.en;
    assign transfer_done_flag_o   = q.done;
    assign write_collision_flag_o = q.wcol;
    assign mode_fault_flag_o      = q.modf;
    assign tx_buffer_empty_flag_o = q.txbmt;
    assign busy_o                 = q.busy;
    assign irq_o                  = q.irq;
    assign sck_o                  = q.sck;
    assign mosi_o                 = q.sh[MSB];
    assign miso_o                 = slv_miso;
    assign miso_oe_o              = slv_oe;

    // Helper for checks: leading clock edges within the current byte
    assign lead = (n.sck != clock_polarity_bit_i) &&
                  (q.sck == clock_polarity_bit_i);

    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
            lead_cnt_ff <= '0;
        else if (!n.busy)
            lead_cnt_ff <= '0;
        else if (lead)
            lead_cnt_ff <= lead_cnt_ff + 1'b1;
    end

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (reset_i);

    sequence s_ready_to_load;
        q.st == M_IDLE && q.en && q.master_enable_bit && !q.txbmt;
    endsequence

    sequence s_started;
        busy_o && tx_buffer_empty_flag_o;
    endsequence

    property p_start;
        s_ready_to_load |=> s_started;
    endproperty
    a_start: assert property (p_start)
        else $error("queued byte did not start");

    property p_empty_drop;
        wr_ok && tx_buffer_empty_flag_o && q.st == M_SHIFT
        |=> !tx_buffer_empty_flag_o;
    endproperty
    a_empty_drop: assert property (p_empty_drop)
        else $error("buffer empty flag did not drop");

    property p_wcol;
        wr_ok && !tx_buffer_empty_flag_o
        |=> write_collision_flag_o && $stable(q.txbuf);
    endproperty
    a_wcol: assert property (p_wcol)
        else $error("collision missed or buffer overwritten");

    property p_modf;
        fault |=> mode_fault_flag_o && !master_enable_bit_o
                  && !block_enable_bit_o ##1 !busy_o;
    endproperty
    a_modf: assert property (p_modf)
        else $error("mode fault not handled");

    property p_done_set_wins;
        byte_end && clr_done_i |=> transfer_done_flag_o;
    endproperty
    a_done_set_wins: assert property (p_done_set_wins)
        else $error("done set lost to clear");

    property p_irq;
        transfer_done_flag_o && $past(int_enable_i) |-> irq_o;
    endproperty
    a_irq: assert property (p_irq)
        else $error("no interrupt for finished byte");

    property p_byte_len;
        byte_end |-> lead_cnt_ff == '0 && busy_o;
    endproperty
    a_byte_len: assert property (p_byte_len)
        else $error("byte did not span eight clocks");

    property p_rx_copy;
        byte_end |=> rx_byte_o == {$past(q.sh[BYTE_W-2:0]), $past(slv_miso)};
    endproperty
    a_rx_copy: assert property (p_rx_copy)
        else $error("receive buffer not loaded");

    property p_half_min;
        busy_o && $changed(sck_o) && $stable(clock_polarity_bit_i)
        |=> $stable(sck_o)[*3];
    endproperty
    a_half_min: assert property (p_half_min)
        else $error("serial clock half period too short");

    property p_miso_hiz;
        !block_enable_bit_o |=> !miso_oe_o;
    endproperty
    a_miso_hiz: assert property (p_miso_hiz)
        else $error("miso driven while disabled");

    property p_mosi_msb;
        $rose(busy_o) |-> mosi_o == $past(q.txbuf[MSB]);
    endproperty
    a_mosi_msb: assert property (p_mosi_msb)
        else $error("first bit out is not the top bit");

endmodule
`default_nettype wire

// ===== src/radio_link_pkg.sv
// Shared constants and types for the radio register link
package radio_link_pkg;

    // Data path widths and radio register space
    localparam int BYTE_W   = 8;
    localparam int ADDR_W   = 7;
    localparam int NUM_REGS = 128;
    localparam int MSB      = BYTE_W - 1;

    // Clock divider and half-period counter widths
    localparam int DIV_W = 8;
    localparam int CNT_W = DIV_W + 1;

    // Serial clock ceiling: 12.5 MHz is an 80 ns period
    localparam int SYS_PERIOD_NS     = 10;
    localparam int SCK_MIN_PERIOD_NS = 80;
    // Least half period rounds up to whole system clocks
    localparam int HALF_MIN_CYC =
        (SCK_MIN_PERIOD_NS / 2 + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam logic [CNT_W-1:0] HALF_MIN_CNT = CNT_W'(HALF_MIN_CYC);
    localparam logic [CNT_W-1:0] CNT_ONE      = 9'h001;

    // Bit positions and frame encodings
    localparam logic [2:0] LAST_BIT  = 3'h7;
    localparam logic       RW_WRITE  = 1'b1;
    localparam logic       IDLE_MISO = 1'b1;

    // Read-out bit counts for the radio slave
    localparam logic [3:0] OUT_FULL  = 4'h8;
    localparam logic [3:0] OUT_BURST = 4'h7;

    // Master sequencer states
    typedef enum logic {M_IDLE, M_SHIFT} mst_e;

endpackage

// ===== src/radio_reg_slave.sv
// Register-access serial slave of the radio with 128 byte registers
`timescale 1ns/1ps
`default_nettype none

module radio_reg_slave
(
    input  wire logic sys_clk_i,        // System clock
    input  wire logic reset_i,          // Async reset, active high
    input  wire logic enable_i,         // Link enabled, drive miso
    input  wire logic slave_select_n_i, // Frame select, active low
    input  wire logic sck_i,            // Serial clock from master
    input  wire logic mosi_i,           // Serial data from master
    output logic      miso_o,           // Serial data to master
    output logic      miso_oe_o         // Miso driver enable
);
    import radio_link_pkg::*;

    typedef struct packed {
        logic              sck;
        logic              hdr;
        logic [2:0]        bitn;
        logic [BYTE_W-1:0] in_sh;
        logic              rw;
        logic [ADDR_W-1:0] addr;
        logic [BYTE_W-1:0] out_sh;
        logic [3:0]        out_cnt;
        logic              burst;
        logic              miso;
        logic              oe;
    } slv_s;

    localparam slv_s SLV_RST = '{miso: IDLE_MISO, default: '0};

    logic [BYTE_W-1:0] regs [NUM_REGS];
    slv_s              q;
    slv_s              n;
    logic              wr_en;
    logic [BYTE_W-1:0] shifted;

    // Frame decode on sck edges seen in the system clock domain
    always_comb
    begin
        n       = q;
        wr_en   = 1'b0;
        shifted = {q.in_sh[BYTE_W-2:0], mosi_i};
        n.sck   = sck_i;
        n.oe    = enable_i;
        if (slave_select_n_i)
        begin
            // Deselected: clocks ignored, next frame starts afresh
            n.hdr     = 1'b0;
            n.bitn    = '0;
            n.out_cnt = '0;
            n.burst   = 1'b0;
            n.miso    = IDLE_MISO;
        end
        else if (sck_i && !q.sck)
        begin
            n.in_sh = shifted;
            n.bitn  = q.bitn + 1'b1;
            if (q.burst)
            begin
                // Burst read: next register's top bit goes out at once
                n.miso    = regs[q.addr][MSB];
                n.out_sh  = {regs[q.addr][BYTE_W-2:0], 1'b0};
                n.out_cnt = OUT_BURST;
                n.burst   = 1'b0;
            end
            if (q.bitn == LAST_BIT)
            begin
                if (!q.hdr)
                begin
                    // Header byte: direction then 7-bit address
                    n.hdr  = 1'b1;
                    n.rw   = shifted[MSB];
                    n.addr = shifted[ADDR_W-1:0];
                    if (shifted[MSB] != RW_WRITE)
                    begin
                        n.out_sh  = regs[shifted[ADDR_W-1:0]];
                        n.out_cnt = OUT_FULL;
                    end
                end
                else
                begin
                    n.addr = q.addr + 1'b1;
                    if (q.rw == RW_WRITE)
                        wr_en = 1'b1;
                    else
                        n.burst = 1'b1;
                end
            end
        end
        else if (!sck_i && q.sck && q.out_cnt != '0)
        begin
            // Falling edges shift read data out; last bit is held
            n.miso    = q.out_sh[MSB];
            n.out_sh  = {q.out_sh[BYTE_W-2:0], 1'b0};
            n.out_cnt = q.out_cnt - 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
            q <= SLV_RST;
        else
            q <= n;
    end

    // Register array carries no reset to stay a plain memory
    always_ff @(posedge sys_clk_i)
    begin
        if (wr_en)
            regs[q.addr] <= shifted;
    end

    assign miso_o    = q.miso;
    assign miso_oe_o = q.oe;

    property p_idle_high;
        @(posedge sys_clk_i) disable iff (reset_i)
        slave_select_n_i |=> miso_o && q.bitn == '0 && !q.hdr;
    endproperty
    a_idle_high: assert property (p_idle_high)
        else $error("slave not idle while deselected");

endmodule
`default_nettype wire

// ===== verif/radio_host_model.sv
// Software-side model: radio select port pin and link setup values
`timescale 1ns/1ps
`default_nettype none

module radio_host_model
(
    input  wire logic sys_clk_i,        // System clock
    input  wire logic reset_i,          // Async reset, active high
    input  wire logic want_sel_i,       // Software asks for the radio
    output logic      slave_select_n_o, // Radio select pin, low
    output logic      clock_phase_o,    // Phase for the radio
    output logic      clock_polarity_o, // Idle clock level
    output logic [radio_link_pkg::DIV_W-1:0]
                      clock_divider_o   // Half period - 1
);
    import radio_link_pkg::*;

    // The radio only samples correctly with both bits at zero
    assign clock_phase_o    = 1'b0;
    assign clock_polarity_o = 1'b0;
    // Five clocks a half period is 10 MHz, the radio's ceiling
    assign clock_divider_o  = 8'h04;

    // Select is a plain port pin, so it trails the software by a clock
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
            slave_select_n_o <= 1'b1;
        else
            slave_select_n_o <= ~want_sel_i;
    end
endmodule

`default_nettype wire

// ===== verif/tb_radio_link_spi.sv
// Self-checking bench for the radio register link
`timescale 1ns/1ps
`default_nettype none

module tb_radio_link_spi;
    import radio_link_pkg::*;

    logic              sys_clk_i, reset_i, ctrl_wr_i, want_sel;
    logic              master_enable_i, block_enable_i, multi_master_i;
    logic              fault_select_n_i, slave_select_n_i, int_enable_i;
    logic              clock_phase_bit_i, clock_polarity_bit_i, data_wr_i;
    logic              clr_done_i, clr_collision_i, clr_fault_i;
    logic [DIV_W-1:0]  clock_divider_register_i;
    logic [BYTE_W-1:0] data_wr_byte_i, rx_byte_o, wire_sh;
    logic              master_enable_bit_o, block_enable_bit_o, busy_o;
    logic              transfer_done_flag_o, write_collision_flag_o;
    logic              mode_fault_flag_o, tx_buffer_empty_flag_o, irq_o;
    logic              sck_o, mosi_o, miso_o, miso_oe_o;
    int                err_total, checks_done, cyc, last_rise, sck_per;

    radio_host_model u_radio_host_model (.sys_clk_i, .reset_i,
        .want_sel_i(want_sel), .slave_select_n_o(slave_select_n_i),
        .clock_phase_o(clock_phase_bit_i),
        .clock_polarity_o(clock_polarity_bit_i),
        .clock_divider_o(clock_divider_register_i));

    radio_link_spi u_radio_link_spi (.sys_clk_i, .reset_i, .ctrl_wr_i,
        .master_enable_i, .block_enable_i, .clock_phase_bit_i,
        .clock_polarity_bit_i, .clock_divider_register_i, .multi_master_i,
        .fault_select_n_i, .slave_select_n_i, .int_enable_i, .data_wr_i,
        .data_wr_byte_i, .clr_done_i, .clr_collision_i, .clr_fault_i,
        .rx_byte_o, .master_enable_bit_o, .block_enable_bit_o,
        .transfer_done_flag_o, .write_collision_flag_o, .mode_fault_flag_o,
        .tx_buffer_empty_flag_o, .busy_o, .irq_o, .sck_o, .mosi_o, .miso_o,
        .miso_oe_o);

    // 100 MHz system clock
    initial
    begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    // Cycle count on falling system edges; the wire is sampled on each rising serial clock edge
    always @(negedge sys_clk_i) cyc <= cyc + 1;
    always @(posedge sck_o)
    begin
        wire_sh   = {wire_sh[MSB-1:0], mosi_o};
        sck_per   = cyc - last_rise;
        last_rise = cyc;
    end

    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Strobes are one clock wide, raised and lowered on falling edges
    task automatic pulse_wr(input logic [7:0] b);
        data_wr_byte_i = b;
        data_wr_i      = 1'b1;
        @(negedge sys_clk_i);
        data_wr_i      = 1'b0;
    endtask

    task automatic send(input logic [7:0] b);
        int n;
        n = 0;
        while (tx_buffer_empty_flag_o !== 1'b1 && n < 300)
        begin
            @(negedge sys_clk_i);
            n++;
        end
        pulse_wr(b);
    endtask

    // One byte both ways, then the done flag is cleared by software
    task automatic xfer(input logic [7:0] b, input logic [7:0] exp,
                        input bit chk_rx);
        int n;
        n = 0;
        send(b);
        while (transfer_done_flag_o !== 1'b1 && n < 300)
        begin
            @(negedge sys_clk_i);
            n++;
        end
        @(negedge sys_clk_i);
        check("done", 8'h01, 8'(transfer_done_flag_o));
        check("irq", 8'(int_enable_i), 8'(irq_o));
        check("mosi_bits", b, wire_sh);
        check("sck_period", 8'(2 * (clock_divider_register_i + 1)),
              8'(sck_per));
        check("sck_idle", 8'h00, 8'(sck_o));
        if (chk_rx)
            check("rx_byte", exp, rx_byte_o);
        clr_done_i = 1'b1;
        @(negedge sys_clk_i);
        clr_done_i = 1'b0;
        @(negedge sys_clk_i);
        check("irq_clear", 8'h00, 8'(irq_o));
    endtask

    // Select high periods well above the radio's minimum
    task automatic sel(input logic v);
        want_sel = v;
        repeat (10) @(negedge sys_clk_i);
    endtask

    initial
    begin
        repeat (20000) @(posedge sys_clk_i);
        err_total++;
        end_sim();
    end

    initial
    begin
        {ctrl_wr_i, master_enable_i, block_enable_i, multi_master_i} = '0;
        {int_enable_i, data_wr_i, clr_done_i, clr_collision_i} = '0;
        {clr_fault_i, want_sel, err_total, checks_done, cyc} = '0;
        {last_rise, sck_per} = '0;
        data_wr_byte_i   = 8'h00;
        fault_select_n_i = 1'b1;
        reset_i          = 1'b1;
        repeat (6) @(negedge sys_clk_i);
        reset_i = 1'b0;
        @(negedge sys_clk_i);
        check("miso_oe_off", 8'h00, 8'(miso_oe_o));
        check("miso_idle", 8'h01, 8'(miso_o));
        check("tx_empty_rst", 8'h01, 8'(tx_buffer_empty_flag_o));
        {ctrl_wr_i, master_enable_i, block_enable_i} = 3'h7;
        @(negedge sys_clk_i);
        ctrl_wr_i = 1'b0;
        check("master_en", 8'h01, 8'(master_enable_bit_o));
        @(negedge sys_clk_i);
        check("miso_oe_on", 8'h01, 8'(miso_oe_o));
        int_enable_i = 1'b1;
        // Burst write to the top register, wrapping to register zero
        sel(1'b1);
        xfer(8'hFF, 8'h00, 1'b0);
        xfer(8'hA5, 8'h00, 1'b0);
        xfer(8'h3C, 8'h00, 1'b0);
        sel(1'b0);
        // Burst read back, header byte with the interrupt masked
        sel(1'b1);
        int_enable_i = 1'b0;
        xfer(8'h7F, 8'h00, 1'b0);
        int_enable_i = 1'b1;
        xfer(8'h00, 8'hA5, 1'b1);
        // Nonzero data on a read must not land in the register
        xfer(8'hC3, 8'h3C, 1'b1);
        check("miso_hold", 8'h00, 8'(miso_o));
        sel(1'b0);
        check("miso_pull", 8'h01, 8'(miso_o));
        // Third byte written while the buffer is full must be dropped
        sel(1'b1);
        send(8'hFF);
        send(8'h5A);
        check("tx_empty_low", 8'h00, 8'(tx_buffer_empty_flag_o));
        // Let the strobe fall for a clock so each write is its own pulse
        @(negedge sys_clk_i);
        pulse_wr(8'hC3);
        check("collision", 8'h01, 8'(write_collision_flag_o));
        // Clear held over both byte ends: the hardware set must still win
        clr_done_i = 1'b1;
        repeat (200) @(negedge sys_clk_i);
        check("idle_after", 8'h00, 8'(busy_o));
        {clr_done_i, clr_collision_i} = 2'h3;
        @(negedge sys_clk_i);
        {clr_done_i, clr_collision_i} = 2'h0;
        sel(1'b0);
        sel(1'b1);
        xfer(8'h7F, 8'h00, 1'b0);
        xfer(8'h00, 8'h5A, 1'b1);
        xfer(8'h00, 8'h3C, 1'b1);
        sel(1'b0);
        // Mode fault drops both enables and releases the radio line
        {multi_master_i, fault_select_n_i} = 2'h2;
        repeat (3) @(negedge sys_clk_i);
        check("mode_fault", 8'h01, 8'(mode_fault_flag_o));
        check("block_en", 8'h00, 8'(block_enable_bit_o));
        check("master_off", 8'h00, 8'(master_enable_bit_o));
        check("fault_irq", 8'h01, 8'(irq_o));
        check("miso_oe_dis", 8'h00, 8'(miso_oe_o));
        {multi_master_i, fault_select_n_i, clr_fault_i} = 3'h3;
        @(negedge sys_clk_i);
        clr_fault_i = 1'b0;
        @(negedge sys_clk_i);
        check("fault_clr", 8'h00, 8'(mode_fault_flag_o));
        end_sim();
    end
endmodule

`default_nettype wire
